// ==== core/signal_measure_timer.sv ====
// signal measure timer: counter, capture latches, period match and modes
`timescale 1ns/1ps
module signal_measure_timer #(
    parameter int N_SRC = 4,
    parameter int SEL_W = 2
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // oscillator pins
    input wire logic HF_OSC,
    input wire logic LF_OSC,
    input wire logic MF_OSC,
    // measured signal and window sources
    input wire logic [N_SRC-1:0] SIG_SRC,
    input wire logic [N_SRC-1:0] WIN_SRC,
    // configuration levels
    input wire logic [2:0] CLOCK_SOURCE_SELECT,
    input wire logic [1:0] CLOCK_PRESCALE,
    input wire logic [3:0] MODE,
    input wire logic [SEL_W-1:0] SIG_SEL,
    input wire logic [SEL_W-1:0] WIN_SEL,
    input wire logic SIG_POL,
    input wire logic WIN_POL,
    input wire logic NARROW_MODE,
    input wire logic REPEAT,
    input wire logic HALT_ON_MATCH,
    // software strobes
    input wire logic RUN_SET,
    input wire logic RUN_CLR,
    input wire logic COUNTER_CLEAR,
    input wire logic WIDTH_LATCH_UPDATE,
    input wire logic PERIOD_LATCH_UPDATE,
    input wire logic MATCH_FLAG_CLR,
    input wire logic ACQ_FLAG_CLR,
    // byte write port
    input wire logic WR_EN,
    input wire logic [1:0] WR_TARGET,
    input wire logic [1:0] WR_BYTE,
    input wire logic [7:0] WR_DATA,
    // read-back
    output logic [23:0] MEASURE_COUNTER,
    output logic [23:0] PULSE_WIDTH_LATCH,
    output logic [23:0] PERIOD_LATCH,
    output logic [23:0] PERIOD_VALUE,
    output logic RUN_CONTROL_BIT,
    output logic MATCH_FLAG,
    output logic ACQ_FLAG,
    output logic SIGNAL_STATUS,
    output logic WINDOW_STATUS
);
    // ----------------------------------------------------------------
    // front end
    // ----------------------------------------------------------------
    measure_bus_if mb ();

    // every register below is private, so two instances never interact
    measure_clock_front #(.N_SRC(N_SRC), .SEL_W(SEL_W)) u_front (
        .clk(CLK),
        .rst_n(RST_N),
        .hf_osc(HF_OSC),
        .lf_osc(LF_OSC),
        .mf_osc(MF_OSC),
        .clock_source_select(CLOCK_SOURCE_SELECT),
        .psel(CLOCK_PRESCALE),
        .sig_src(SIG_SRC),
        .win_src(WIN_SRC),
        .sig_sel(SIG_SEL),
        .win_sel(WIN_SEL),
        .sig_pol(SIG_POL),
        .win_pol(WIN_POL),
        .mb(mb.front)
    );

    logic [23:0] cnt_q, cnt_d;
    logic [23:0] cpw_q, cpw_d;
    logic [23:0] cpr_q, cpr_d;
    logic [23:0] pr_q, pr_d;
    logic run_q, run_d;
    logic pm_q, pm_d;
    logic acq_q, acq_d;
    logic sig_prev_q;
    logic win_prev_q;
    logic sig_stat_q;
    logic win_stat_q;

    // ----------------------------------------------------------------
    // edges and mode decode
    // ----------------------------------------------------------------
    logic step;
    logic sig_rise, sig_fall, win_rise, win_fall;
    logic inc, rst_evt, cpw_evt, cpr_evt, acq_evt;
    logic [23:0] rst_val;

    assign step = run_q && mb.tick;
    assign sig_rise = step && mb.sig_lvl && !sig_prev_q;
    assign sig_fall = step && !mb.sig_lvl && sig_prev_q;
    assign win_rise = step && mb.win_lvl && !win_prev_q;
    assign win_fall = step && !mb.win_lvl && win_prev_q;

    always_comb begin
        inc = 1'b0;
        rst_evt = 1'b0;
        rst_val = smt_pkg::CNT_ZERO;
        cpw_evt = 1'b0;
        cpr_evt = 1'b0;
        acq_evt = 1'b0;
        case (MODE)
            smt_pkg::MODE_TIMER: begin
                inc = 1'b1;
            end
            smt_pkg::MODE_GATED_TIMER: begin
                inc = mb.sig_lvl;
                cpw_evt = sig_fall;
                acq_evt = sig_fall;
            end
            smt_pkg::MODE_PERIOD_DUTY: begin
                inc = 1'b1;
                cpw_evt = sig_fall;
                cpr_evt = sig_rise;
                rst_evt = sig_rise;
                rst_val = smt_pkg::CNT_ONE;
                acq_evt = sig_rise;
            end
            smt_pkg::MODE_HIGH_LOW: begin
                inc = 1'b1;
                cpw_evt = sig_fall;
                cpr_evt = sig_rise;
                rst_evt = sig_rise || sig_fall;
                acq_evt = sig_rise;
            end
            smt_pkg::MODE_WINDOWED, smt_pkg::MODE_WIN_COUNTER: begin
                inc = 1'b1;
                cpr_evt = win_rise;
                rst_evt = win_rise;
                acq_evt = win_rise;
            end
            smt_pkg::MODE_GATED_WINDOW: begin
                inc = mb.sig_lvl;
                cpr_evt = win_rise;
                rst_evt = win_rise;
                acq_evt = win_rise;
            end
            smt_pkg::MODE_FLIGHT: begin
                inc = 1'b1;
                rst_evt = win_rise;
                cpr_evt = sig_rise;
                acq_evt = sig_rise;
            end
            smt_pkg::MODE_CAPTURE: begin
                inc = 1'b1;
                cpw_evt = sig_rise;
                cpr_evt = win_rise;
                acq_evt = sig_rise || win_rise;
            end
            smt_pkg::MODE_COUNTER: begin
                inc = 1'b1;
            end
            smt_pkg::MODE_GATED_COUNTER: begin
                inc = mb.win_lvl;
                cpw_evt = win_fall;
                acq_evt = win_fall;
            end
            // reserved codes stop counting; a period match still clears the counter
            default: begin
                inc = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // counter datapath
    // ----------------------------------------------------------------
    logic [23:0] cmp_mask;
    logic [23:0] cnt_inc;
    logic match;
    logic [23:0] wr_mask;
    logic [23:0] wr_word;
    logic wr_cnt, wr_cpw, wr_pr, wr_cpr;

    assign cmp_mask = NARROW_MODE ? smt_pkg::NARROW_MASK : smt_pkg::FULL_MASK;
    assign match = (cnt_q & cmp_mask) == (pr_q & cmp_mask);
    assign cnt_inc = (cnt_q + smt_pkg::CNT_ONE) & cmp_mask;

    assign wr_mask = smt_pkg::BYTE_MASK << (smt_pkg::BYTE_SHIFT * {3'h0, WR_BYTE});
    assign wr_word = {WR_DATA, WR_DATA, WR_DATA} & wr_mask;
    assign wr_cnt = WR_EN && (WR_TARGET == smt_pkg::WSEL_COUNTER);
    assign wr_cpw = WR_EN && (WR_TARGET == smt_pkg::WSEL_WIDTH);
    assign wr_pr = WR_EN && (WR_TARGET == smt_pkg::WSEL_PERIOD);
    assign wr_cpr = WR_EN && (WR_TARGET == smt_pkg::WSEL_PLATCH);

    // clear beats writes, writes beat counting; halting leaves the match standing
    assign cnt_d = COUNTER_CLEAR ? smt_pkg::CNT_ZERO :
                   wr_cnt ? ((cnt_q & ~wr_mask) | wr_word) :
                   !step ? cnt_q :
                   (match && HALT_ON_MATCH) ? cnt_q :
                   match ? smt_pkg::CNT_ZERO :
                   rst_evt ? rst_val :
                   inc ? cnt_inc : cnt_q;

    assign cpw_d = wr_cpw ? ((cpw_q & ~wr_mask) | wr_word) :
                   (WIDTH_LATCH_UPDATE || cpw_evt) ? cnt_q : cpw_q;
    assign cpr_d = wr_cpr ? ((cpr_q & ~wr_mask) | wr_word) :
                   (PERIOD_LATCH_UPDATE || cpr_evt) ? cnt_q : cpr_q;
    assign pr_d = wr_pr ? ((pr_q & ~wr_mask) | wr_word) : pr_q;

    // ----------------------------------------------------------------
    // run control and flags
    // ----------------------------------------------------------------
    // a software start in the same cycle as a completion wins
    assign run_d = RUN_SET ? 1'b1 :
                   (RUN_CLR || (acq_evt && !REPEAT)) ? 1'b0 : run_q;
    assign pm_d = (step && match) ? 1'b1 : (MATCH_FLAG_CLR ? 1'b0 : pm_q);
    assign acq_d = acq_evt ? 1'b1 : (ACQ_FLAG_CLR ? 1'b0 : acq_q);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_q <= smt_pkg::CNT_ZERO;
            cpw_q <= smt_pkg::CNT_ZERO;
            cpr_q <= smt_pkg::CNT_ZERO;
            pr_q <= smt_pkg::PERIOD_RESET;
            run_q <= 1'b0;
            pm_q <= 1'b0;
            acq_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            cpw_q <= cpw_d;
            cpr_q <= cpr_d;
            pr_q <= pr_d;
            run_q <= run_d;
            pm_q <= pm_d;
            acq_q <= acq_d;
        end
    end

    // edge history follows the prescaled tick only
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sig_prev_q <= 1'b0;
            win_prev_q <= 1'b0;
            sig_stat_q <= 1'b0;
            win_stat_q <= 1'b0;
        end else begin
            sig_prev_q <= mb.tick ? mb.sig_lvl : sig_prev_q;
            win_prev_q <= mb.tick ? mb.win_lvl : win_prev_q;
            sig_stat_q <= mb.sig_lvl;
            win_stat_q <= mb.win_lvl;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // byte reads are not atomic; software reads while stopped
    assign MEASURE_COUNTER = cnt_q;
    assign PULSE_WIDTH_LATCH = cpw_q;
    assign PERIOD_LATCH = cpr_q;
    assign PERIOD_VALUE = pr_q;
    assign RUN_CONTROL_BIT = run_q;
    assign MATCH_FLAG = pm_q;
    assign ACQ_FLAG = acq_q;
    assign SIGNAL_STATUS = sig_stat_q;
    assign WINDOW_STATUS = win_stat_q;
endmodule // signal_measure_timer

// ==== core/smt_pkg.sv ====
// shared constants for the signal measurement timer
package smt_pkg;
    localparam int CNT_W = 24;
    localparam int BYTE_W = 8;
    localparam int OSC_N = 3;
    localparam logic [23:0] CNT_ZERO = 24'h000000;
    localparam logic [23:0] CNT_ONE = 24'h000001;
    localparam logic [23:0] BYTE_MASK = 24'h0000FF;
    localparam logic [23:0] NARROW_MASK = 24'h00FFFF;
    localparam logic [23:0] FULL_MASK = 24'hFFFFFF;
    localparam logic [23:0] PERIOD_RESET = 24'hFFFFFF;
    localparam logic [4:0] BYTE_SHIFT = 5'h08;

    // operating modes
    localparam logic [3:0] MODE_TIMER = 4'h0;
    localparam logic [3:0] MODE_GATED_TIMER = 4'h1;
    localparam logic [3:0] MODE_PERIOD_DUTY = 4'h2;
    localparam logic [3:0] MODE_HIGH_LOW = 4'h3;
    localparam logic [3:0] MODE_WINDOWED = 4'h4;
    localparam logic [3:0] MODE_GATED_WINDOW = 4'h5;
    localparam logic [3:0] MODE_FLIGHT = 4'h6;
    localparam logic [3:0] MODE_CAPTURE = 4'h7;
    localparam logic [3:0] MODE_COUNTER = 4'h8;
    localparam logic [3:0] MODE_GATED_COUNTER = 4'h9;
    localparam logic [3:0] MODE_WIN_COUNTER = 4'hA;

    // clock source select codes
    localparam logic [2:0] CSRC_SYS = 3'h0;
    localparam logic [2:0] CSRC_SYS_DIV4 = 3'h1;
    localparam logic [2:0] CSRC_HF_OSC = 3'h2;
    localparam logic [2:0] CSRC_LF_OSC = 3'h3;
    localparam logic [2:0] CSRC_MF_OSC = 3'h4;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam logic [2:0] PRESC_ONE = 3'h1;

    // software write targets
    localparam logic [1:0] WSEL_COUNTER = 2'h0;
    localparam logic [1:0] WSEL_WIDTH = 2'h1;
    localparam logic [1:0] WSEL_PERIOD = 2'h2;
    localparam logic [1:0] WSEL_PLATCH = 2'h3;
endpackage

// ==== core/measure_bus_if.sv ====
// prescaled tick and sampled input levels from the clock front end
`timescale 1ns/1ps
interface measure_bus_if;
    logic tick;
    logic sig_lvl;
    logic win_lvl;
    modport front (output tick, output sig_lvl, output win_lvl);
    modport core (input tick, input sig_lvl, input win_lvl);
endinterface

// ==== core/measure_clock_front.sv ====
// clock source select, prescaler and input synchronisers
`timescale 1ns/1ps
module measure_clock_front #(
    parameter int N_SRC = 4,
    parameter int SEL_W = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // oscillator pins and selection
    input wire logic hf_osc,
    input wire logic lf_osc,
    input wire logic mf_osc,
    input wire logic [2:0] clock_source_select,
    input wire logic [1:0] psel,
    // measured inputs
    input wire logic [N_SRC-1:0] sig_src,
    input wire logic [N_SRC-1:0] win_src,
    input wire logic [SEL_W-1:0] sig_sel,
    input wire logic [SEL_W-1:0] win_sel,
    input wire logic sig_pol,
    input wire logic win_pol,
    // to the core
    measure_bus_if.front mb
);
    localparam int NR = smt_pkg::OSC_N + 2 * N_SRC;

    logic [NR-1:0] raw;
    logic [NR-1:0] s1_q;
    logic [NR-1:0] s2_q;
    logic [smt_pkg::OSC_N-1:0] osc_prev_q;
    logic [smt_pkg::OSC_N-1:0] osc_rise;
    logic [1:0] div4_q;
    logic [2:0] pcnt_q;
    logic [2:0] pmask;
    logic src_tick;
    logic presc_tick;
    logic [N_SRC-1:0] sig_s;
    logic [N_SRC-1:0] win_s;
    logic sig_pick;
    logic win_pick;
    logic tick_q;
    logic sig_q;
    logic win_q;

    assign raw = {win_src, sig_src, mf_osc, lf_osc, hf_osc};

    // two-stage synchronisers, one per raw pin
    genvar g;
    generate
        for (g = 0; g < NR; g++) begin : g_sync
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_q[g] <= 1'b0;
                    s2_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= raw[g];
                    s2_q[g] <= s1_q[g];
                end
            end
        end
    endgenerate

    assign osc_rise = s2_q[smt_pkg::OSC_N-1:0] & ~osc_prev_q;
    assign src_tick = (clock_source_select == smt_pkg::CSRC_SYS) ? 1'b1 :
                      (clock_source_select == smt_pkg::CSRC_SYS_DIV4) ? (div4_q == smt_pkg::DIV4_LAST) :
                      (clock_source_select == smt_pkg::CSRC_HF_OSC) ? osc_rise[0] :
                      (clock_source_select == smt_pkg::CSRC_LF_OSC) ? osc_rise[1] :
                      (clock_source_select == smt_pkg::CSRC_MF_OSC) ? osc_rise[2] : 1'b0;
    // divide by 1, 2, 4 or 8
    assign pmask = (smt_pkg::PRESC_ONE << psel) - smt_pkg::PRESC_ONE;
    assign presc_tick = src_tick && ((pcnt_q & pmask) == pmask);

    assign sig_s = s2_q[smt_pkg::OSC_N +: N_SRC];
    assign win_s = s2_q[smt_pkg::OSC_N + N_SRC +: N_SRC];
    assign sig_pick = sig_s[sig_sel] ^ sig_pol;
    assign win_pick = win_s[win_sel] ^ win_pol;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_prev_q <= '0;
            div4_q <= 2'h0;
            pcnt_q <= 3'h0;
        end else begin
            osc_prev_q <= s2_q[smt_pkg::OSC_N-1:0];
            div4_q <= div4_q + 2'h1;
            pcnt_q <= src_tick ? pcnt_q + 3'h1 : pcnt_q;
        end
    end

    // inputs are resampled on the prescaled clock so edges line up with counting
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_q <= 1'b0;
            sig_q <= 1'b0;
            win_q <= 1'b0;
        end else begin
            tick_q <= presc_tick;
            sig_q <= presc_tick ? sig_pick : sig_q;
            win_q <= presc_tick ? win_pick : win_q;
        end
    end

    assign mb.tick = tick_q;
    assign mb.sig_lvl = sig_q;
    assign mb.win_lvl = win_q;
endmodule // measure_clock_front

// ==== test/smt_asserts.sv ====
// concurrent checks on the measure timer top ports
`timescale 1ns/1ps
module smt_asserts (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // controls
    input wire logic [3:0] MODE,
    input wire logic NARROW_MODE,
    input wire logic REPEAT,
    input wire logic HALT_ON_MATCH,
    input wire logic RUN_SET,
    input wire logic RUN_CLR,
    input wire logic COUNTER_CLEAR,
    input wire logic WIDTH_LATCH_UPDATE,
    input wire logic WR_EN,
    input wire logic [1:0] WR_TARGET,
    input wire logic [1:0] WR_BYTE,
    input wire logic [7:0] WR_DATA,
    // observed
    input wire logic [23:0] MEASURE_COUNTER,
    input wire logic [23:0] PULSE_WIDTH_LATCH,
    input wire logic [23:0] PERIOD_VALUE,
    input wire logic RUN_CONTROL_BIT,
    input wire logic MATCH_FLAG,
    input wire logic ACQ_FLAG
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // no software access to the counter this cycle
    logic quiet;
    assign quiet = !WR_EN && !COUNTER_CLEAR;

    chk_clear_zero: assert property (COUNTER_CLEAR |=> MEASURE_COUNTER == 24'h000000)
        else $error("counter not zero after clear");
    chk_period_write: assert property (WR_EN && WR_TARGET == 2'h2 && WR_BYTE == 2'h0
        |=> PERIOD_VALUE[7:0] == $past(WR_DATA)) else $error("period byte write lost");
    chk_counter_byte: assert property (WR_EN && !COUNTER_CLEAR && WR_TARGET == 2'h0
        && WR_BYTE == 2'h2 |=> MEASURE_COUNTER[23:16] == $past(WR_DATA))
        else $error("counter upper byte write lost");
    chk_width_copy: assert property (WIDTH_LATCH_UPDATE && MODE == 4'h0 && !WR_EN
        |=> PULSE_WIDTH_LATCH == $past(MEASURE_COUNTER)) else $error("width latch copy wrong");
    chk_match_zero: assert property ($rose(MATCH_FLAG) && !$past(HALT_ON_MATCH)
        && $past(quiet) && $past(MODE) == 4'h0 |-> MEASURE_COUNTER == 24'h000000)
        else $error("match without rollover");
    chk_count_step: assert property ($past(RUN_CONTROL_BIT) && $past(MODE) == 4'h0
        && $past(quiet) && !$past(NARROW_MODE) && !$stable(MEASURE_COUNTER)
        |-> MEASURE_COUNTER == $past(MEASURE_COUNTER) + 24'h000001
        || MEASURE_COUNTER == 24'h000000) else $error("counter step not one");
    chk_narrow_top: assert property ($past(NARROW_MODE) && $past(quiet)
        && !$stable(MEASURE_COUNTER) |-> MEASURE_COUNTER[23:16] == 8'h00)
        else $error("narrow counter upper byte set");
    chk_run_start: assert property (RUN_SET |=> RUN_CONTROL_BIT)
        else $error("run not set");
    chk_run_stop: assert property (RUN_CLR && !RUN_SET |=> !RUN_CONTROL_BIT)
        else $error("run not cleared");
    chk_single_stop: assert property ($rose(ACQ_FLAG) && !$past(REPEAT)
        && !$past(RUN_SET) |-> !RUN_CONTROL_BIT) else $error("single acquisition kept running");
    // a match still rolls over in reserved modes, so only non-matching cycles must hold
    chk_reserved_idle: assert property ($past(MODE) > 4'hA && $past(quiet)
        && $past(MEASURE_COUNTER[15:0]) != $past(PERIOD_VALUE[15:0])
        |-> $stable(MEASURE_COUNTER)) else $error("reserved mode counted");
endmodule // smt_asserts

bind signal_measure_timer smt_asserts i_chk (.CLK(CLK), .RST_N(RST_N), .MODE(MODE),
    .NARROW_MODE(NARROW_MODE), .REPEAT(REPEAT), .HALT_ON_MATCH(HALT_ON_MATCH),
    .RUN_SET(RUN_SET), .RUN_CLR(RUN_CLR), .COUNTER_CLEAR(COUNTER_CLEAR),
    .WIDTH_LATCH_UPDATE(WIDTH_LATCH_UPDATE), .WR_EN(WR_EN), .WR_TARGET(WR_TARGET),
    .WR_BYTE(WR_BYTE), .WR_DATA(WR_DATA), .MEASURE_COUNTER(MEASURE_COUNTER),
    .PULSE_WIDTH_LATCH(PULSE_WIDTH_LATCH), .PERIOD_VALUE(PERIOD_VALUE),
    .RUN_CONTROL_BIT(RUN_CONTROL_BIT), .MATCH_FLAG(MATCH_FLAG), .ACQ_FLAG(ACQ_FLAG));

// ==== test/smt_far_side.sv ====
// far-side model: measured signal levels and free-running oscillators
`timescale 1ns/1ps
module smt_far_side #(
    parameter int HF_HALF = 160,
    parameter int LF_HALF = 400,
    parameter int MF_HALF = 240
) (
    // levels asked for by the bench
    input wire logic [3:0] sig_set,
    input wire logic [3:0] win_set,
    // pins toward the timer
    output logic [3:0] sig_src,
    output logic [3:0] win_src,
    output logic hf_osc,
    output logic lf_osc,
    output logic mf_osc
);
    // skewed so edges never sit on the bench clock edge
    assign #7 sig_src = sig_set;
    assign #7 win_src = win_set;
    // oscillators run free; lf and mf drift against the bench clock, hf toggles on its falling edge
    initial begin
        hf_osc = 1'b0;
        forever #(HF_HALF) hf_osc = ~hf_osc;
    end
    initial begin
        lf_osc = 1'b0;
        forever #(LF_HALF + 3) lf_osc = ~lf_osc;
    end
    initial begin
        mf_osc = 1'b0;
        forever #(MF_HALF + 1) mf_osc = ~mf_osc;
    end
endmodule // smt_far_side

// ==== test/signal_measure_timer_tb_top.sv ====
// self-checking bench for the signal measure timer
`timescale 1ns/1ps
module signal_measure_timer_tb_top;
    logic clk, rst_n, hf, lf, mf, spol, wpol, narrow, rpt, halt, wr_en;
    logic run, mflag, aflag, sstat, wstat;
    logic [3:0] sig_set, win_set, sig_src, win_src, mode;
    logic [2:0] clock_source_select;
    logic [1:0] psel, ssel, wsel, wr_tgt, wr_byte;
    logic [7:0] wr_data;
    // strobes: run set, run clear, counter clear, width, period latch, match clr, acq clr
    logic [6:0] stb;
    logic [23:0] cnt, pwl, prl, pval, c, prev;
    logic [23:0] ex [4];
    logic [31:0] seed, t;
    int miscompares, check_count, n;
    int ev [9] = '{66, 33, 16, 8, 16, 8, 3, 5, 0};
    logic [2:0] cs [9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};

    signal_measure_timer i_dut (.CLK(clk), .RST_N(rst_n), .HF_OSC(hf), .LF_OSC(lf),
        .MF_OSC(mf), .SIG_SRC(sig_src), .WIN_SRC(win_src), .CLOCK_SOURCE_SELECT(clock_source_select),
        .CLOCK_PRESCALE(psel), .MODE(mode), .SIG_SEL(ssel), .WIN_SEL(wsel), .SIG_POL(spol),
        .WIN_POL(wpol), .NARROW_MODE(narrow), .REPEAT(rpt), .HALT_ON_MATCH(halt),
        .RUN_SET(stb[0]), .RUN_CLR(stb[1]), .COUNTER_CLEAR(stb[2]),
        .WIDTH_LATCH_UPDATE(stb[3]), .PERIOD_LATCH_UPDATE(stb[4]), .MATCH_FLAG_CLR(stb[5]),
        .ACQ_FLAG_CLR(stb[6]), .WR_EN(wr_en), .WR_TARGET(wr_tgt), .WR_BYTE(wr_byte),
        .WR_DATA(wr_data), .MEASURE_COUNTER(cnt), .PULSE_WIDTH_LATCH(pwl), .PERIOD_LATCH(prl),
        .PERIOD_VALUE(pval), .RUN_CONTROL_BIT(run), .MATCH_FLAG(mflag), .ACQ_FLAG(aflag),
        .SIGNAL_STATUS(sstat), .WINDOW_STATUS(wstat));
    smt_far_side i_far (.sig_set(sig_set), .win_set(win_set), .sig_src(sig_src),
        .win_src(win_src), .hf_osc(hf), .lf_osc(lf), .mf_osc(mf));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [23:0] put(logic [23:0] v, logic [1:0] b, logic [7:0] d);
        v[b*8 +: 8] = d;
        return v;
    endfunction
    function automatic logic [23:0] rd(logic [1:0] g);
        return (g == 2'h0) ? cnt : (g == 2'h1) ? pwl : (g == 2'h2) ? pval : prl;
    endfunction

    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic pulse(input int i);
        @(negedge clk);
        stb[i] = 1'b1;
        @(negedge clk);
        stb[i] = 1'b0;
    endtask
    task automatic wr(input logic [1:0] g, input logic [1:0] b, input logic [7:0] d);
        @(negedge clk);
        wr_en = 1'b1;
        wr_tgt = g;
        wr_byte = b;
        wr_data = d;
        @(negedge clk);
        wr_en = 1'b0;
    endtask
    task automatic wr24(input logic [1:0] g, input logic [23:0] v);
        for (int b = 0; b < 3; b++) wr(g, b[1:0], v[b*8 +: 8]);
    endtask
    task automatic close_out();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #(40 * 20000);
        miscompares++;
        close_out();
    end

    initial begin
        {rst_n, spol, wpol, narrow, rpt, halt, wr_en, stb} = '0;
        {sig_set, win_set, mode, clock_source_select, psel, ssel, wsel, wr_tgt, wr_byte, wr_data} = '0;
        seed = 32'h0F9C29D8;
        repeat (3) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        chk(cnt, 24'h000000, "reset cnt");
        chk(pval, 24'hFFFFFF, "reset period");
        chk(pwl, 24'h000000, "reset width latch");
        chk(prl, 24'h000000, "reset period latch");
        chk({run, mflag, aflag}, 24'h000000, "reset flags");
        // timer stopped while bytes are written, as software must
        ex = '{24'h000000, 24'h000000, 24'hFFFFFF, 24'h000000};
        wr(2'h2, 2'h3, 8'h5A);
        chk(pval, ex[2], "byte code 3");
        for (int i = 0; i < 24; i++) begin
            t = rnd();
            wr(t[1:0], t[3:2], t[15:8]);
            if (t[3:2] != 2'h3) ex[t[1:0]] = put(ex[t[1:0]], t[3:2], t[15:8]);
            chk(rd(t[1:0]), ex[t[1:0]], "byte write");
        end
        c = cnt;
        pulse(3);
        chk(pwl, c, "width update");
        pulse(4);
        chk(prl, c, "period latch update");
        pulse(2);
        chk(cnt, 24'h000000, "clear");
        // free timer with short period: step each cycle, rollover to 0 after 5
        wr24(2'h2, 24'h000005);
        pulse(0);
        for (n = 0; n < 40 && mflag !== 1'b1; n++) @(negedge clk);
        chk(mflag, 1'b1, "first match flag");
        chk(cnt, 24'h000000, "first match");
        for (int i = 0; i < 12; i++) begin
            prev = cnt;
            @(negedge clk);
            chk(cnt, (prev == 24'h000005) ? 24'h000000 : prev + 24'h000001, "step");
        end
        halt = 1'b1;
        for (n = 0; n < 20 && cnt !== 24'h000005; n++) @(negedge clk);
        repeat (4) @(negedge clk);
        chk(cnt, 24'h000005, "halt hold");
        chk(mflag, 1'b1, "halt match flag");
        pulse(5);
        chk(mflag, 1'b1, "halt flag persists");
        halt = 1'b0;
        pulse(1);
        chk(run, 1'b0, "run clear");
        // clock source and prescale table, counts over a fixed span
        wr24(2'h2, 24'hFFFFFF);
        for (int k = 0; k < 9; k++) begin
            clock_source_select = cs[k];
            psel = (k < 4) ? k[1:0] : 2'h0;
            pulse(2);
            repeat (8) @(negedge clk);
            pulse(0);
            repeat (64) @(negedge clk);
            pulse(1);
            n = cnt;
            chk(n >= ev[k] - ((k == 8) ? 0 : 2) && n <= ev[k] + ((k == 8) ? 0 : 2), 1'b1,
                "tick rate");
        end
        // reduced width wraps on the low 16 bits
        clock_source_select = 3'h0;
        narrow = 1'b1;
        wr24(2'h0, 24'hFFFFF0);
        pulse(5);
        pulse(0);
        for (n = 0; n < 40 && mflag !== 1'b1; n++) begin
            prev = cnt;
            @(negedge clk);
        end
        chk(prev, 24'h00FFFF, "narrow last count");
        chk(cnt, 24'h000000, "narrow wrap");
        pulse(1);
        narrow = 1'b0;
        // input status follows selected source and polarity
        for (int i = 0; i < 8; i++) begin
            t = rnd();
            {sig_set, win_set, ssel, wsel, spol, wpol} = t[13:0];
            repeat (8) @(negedge clk);
            chk(sstat, sig_set[ssel] ^ spol, "signal status");
            chk(wstat, win_set[wsel] ^ wpol, "window status");
        end
        // capture acquisitions, single then repeated
        {sig_set, ssel, spol, mode} = {4'h0, 2'h0, 1'b0, 4'h7};
        for (int r = 0; r < 2; r++) begin
            rpt = r[0];
            pulse(6);
            pulse(2);
            pulse(0);
            repeat (10) @(negedge clk);
            sig_set = 4'h1;
            for (n = 0; n < 20 && aflag !== 1'b1; n++) @(negedge clk);
            chk({aflag, run}, {1'b1, rpt}, "acquisition end");
            // the latch takes the count of the capturing tick, which then steps once
            chk(pwl, cnt - 24'h000001, "capture latched");
            pulse(1);
            sig_set = 4'h0;
        end
        pulse(6);
        chk(aflag, 1'b0, "acq flag clear");
        // modes 1 to 10: gated ones hold while the gate is low, then both inputs rise
        for (int m = 1; m < 11; m++) begin
            mode = m[3:0];
            {sig_set, win_set, wsel, wpol, rpt} = '0;
            pulse(2);
            pulse(6);
            pulse(0);
            repeat (6) @(negedge clk);
            chk(cnt == 24'h000000, m == 1 || m == 5 || m == 9, "gated hold");
            {sig_set, win_set} = 8'h11;
            repeat (8) @(negedge clk);
            chk(aflag, m != 1 && m != 8 && m != 9, "mode acquisition");
            pulse(1);
        end
        mode = 4'hC;
        pulse(0);
        c = cnt;
        repeat (10) @(negedge clk);
        chk(cnt, c, "reserved mode");
        close_out();
    end
endmodule // signal_measure_timer_tb_top
